/* rtl/cgd_top.sv */
// generator division-factor register and its six dividers
// assumes APB with pstrb; power reset is presetn, user reset a pin
// protection and mode pins are asynchronous and synchronised here
`timescale 1ns/10ps
`default_nettype none
module cgd_top #(
    parameter int CNT_W = 32
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire cgd_pkg::cgd_apb_req_s apb_req,
    output var  cgd_pkg::cgd_apb_rsp_s apb_rsp,
    input  wire logic                 user_reset_req,
    input  wire logic [5:0]           write_lock,
    input  wire logic [5:0]           feeds_rtc,
    input  wire logic [5:0]           divide_mode_select,
    output logic [5:0]                gen_tick
);
    import cgd_pkg::*;

    typedef struct packed {
        logic [GEN_COUNT-1:0][DIV_W-1:0] factor;
        logic [IDX_W-1:0]                index;
        cgd_apb_rsp_s                    rsp;
        logic                            urst_s1;
        logic                            urst_s2;
        logic [GEN_COUNT-1:0]            lock_s1;
        logic [GEN_COUNT-1:0]            lock_s2;
        logic [GEN_COUNT-1:0]            rtc_s1;
        logic [GEN_COUNT-1:0]            rtc_s2;
        logic [GEN_COUNT-1:0]            mode_s1;
        logic [GEN_COUNT-1:0]            mode_s2;
    } cgd_state_s;

    cgd_state_s state;
    cgd_state_s next_state;

    logic setup;
    logic access;
    logic hit;
    logic idx_ok;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    assign setup  = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable & state.rsp.pready;
    assign hit    = (apb_req.paddr == REG_OFFSET);
    // reserved codes select nothing
    assign idx_ok = (apb_req.pwdata[IDX_LSB +: IDX_W] < IDX_W'(GEN_COUNT));

    // read image of the currently indexed generator
    function automatic logic [31:0] read_image(input cgd_state_s s);
        logic [31:0] r;
        r = '0;
        r[IDX_LSB +: IDX_W] = s.index;
        if (s.index < IDX_W'(GEN_COUNT)) begin
            r[DIV_LSB +: DIV_W] = s.factor[s.index[2:0]];
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [3:0] widx;
        widx = apb_req.pwdata[IDX_LSB +: IDX_W];
        next_state = state;

        // pins from outside pass two flops before use
        next_state.urst_s1 = user_reset_req;
        next_state.urst_s2 = state.urst_s1;
        next_state.lock_s1 = write_lock;
        next_state.lock_s2 = state.lock_s1;
        next_state.rtc_s1  = feeds_rtc;
        next_state.rtc_s2  = state.rtc_s1;
        next_state.mode_s1 = divide_mode_select;
        next_state.mode_s2 = state.mode_s1;

        // zero-wait answer: ready is raised in the first access cycle
        next_state.rsp.pready  = setup;
        next_state.rsp.pslverr = setup & ~hit;
        next_state.rsp.prdata  = '0;
        if (setup && hit && !apb_req.pwrite) begin
            next_state.rsp.prdata = read_image(state);
        end
        if (access) begin
            next_state.rsp.pready  = 1'b0;
            next_state.rsp.pslverr = 1'b0;
        end

        if (access && hit && apb_req.pwrite) begin
            // low byte strobe carries the index; the factor needs all four strobes
            if (apb_req.pstrb[0]) begin
                next_state.index = widx;
            end
            if (apb_req.pstrb == STRB_FULL && idx_ok) begin
                next_state.factor[widx[2:0]] =
                    apb_req.pwdata[DIV_LSB +: DIV_W] & cgd_div_mask(widx);
            end
            // full write to a reserved code stores the index but no factor
        end

        // user-class reset, level held while the pin is high
        if (state.urst_s2) begin
            next_state.index = IDX_RESET;
            next_state.factor[0] = DIV_RESET;
            for (int g = 1; g < GEN_COUNT; g++) begin
                // locked or rtc sources keep their value
                if (!state.lock_s2[g] && !state.rtc_s2[g]) begin
                    next_state.factor[g] = DIV_RESET;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // power reset clears all factors, the rtc source too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign apb_rsp = state.rsp;

    // ---------------------------------------------------------------
    // dividers
    // ---------------------------------------------------------------
    generate
        for (genvar g = 0; g < GEN_COUNT; g++) begin : g_div
            cgd_divider #(
                .CNT_W(CNT_W)
            ) u_div (
                .pclk              (pclk),
                .presetn           (presetn),
                .factor            (state.factor[g]),
                .divide_mode_select(state.mode_s2[g]),
                .tick              (gen_tick[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

/* rtl/cgd_pkg.sv */
// package of the generator division-factor register block
// assumes an APB slave with byte strobes, one clock pclk
// Function
// - a full 32-bit write stores the factor into the indexed generator only
// - an 8-bit write sets the index; a later read returns that factor
// - bits 31:24 and 7:4 read zero and ignore writes
// - factor is 16 bits at 23:8, read-write, divides its generator
// - factor width: gen0 8, gen1 16, gen2 5, gen3 onward 8 bits
// - factor bits above a generator's width are dropped, read zero
// - index at 3:0; codes 0-5 select generators, 6-15 are reserved
// - power reset restores every generator, the rtc source included
// - user reset spares gen1-5 when write-locked or feeding the rtc
// - user reset always restores generator zero to all zeros
// - after power reset each image is zero factor plus own index
// - user-reset restore of gen1-5 gives the power-reset image
// - mode clear: divide by factor, 0 or 1 none; set: 2^min(factor+1, CNT_W-1)
`default_nettype none
package cgd_pkg;
    localparam int          GEN_COUNT   = 6;
    localparam int          IDX_W       = 4;
    localparam int          DIV_W       = 16;
    localparam int          IDX_LSB     = 0;
    localparam int          DIV_LSB     = 8;
    localparam logic [31:0] REG_OFFSET  = 32'h0000_0008;
    localparam logic [3:0]  STRB_FULL   = 4'hf;
    localparam logic [3:0]  STRB_BYTE0  = 4'h1;
    localparam logic [15:0] DIV_RESET   = 16'h0000;
    localparam logic [3:0]  IDX_RESET   = 4'h0;
    localparam logic [15:0] MASK_GEN0   = 16'h00ff;
    localparam logic [15:0] MASK_GEN1   = 16'hffff;
    localparam logic [15:0] MASK_GEN2   = 16'h001f;
    localparam logic [15:0] MASK_OTHER  = 16'h00ff;

    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } cgd_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cgd_apb_rsp_s;

    // implemented factor bits per generator
    function automatic logic [15:0] cgd_div_mask(input logic [3:0] idx);
        logic [15:0] m;
        m = MASK_OTHER;
        if (idx == 4'h0) begin
            m = MASK_GEN0;
        end else if (idx == 4'h1) begin
            m = MASK_GEN1;
        end else if (idx == 4'h2) begin
            m = MASK_GEN2;
        end
        return m;
    endfunction
endpackage
`default_nettype wire

/* rtl/cgd_divider.sv */
// one generator's divider: a tick every divided period of pclk
// assumes factor and mode are already in the pclk domain
`timescale 1ns/10ps
`default_nettype none
module cgd_divider #(
    parameter int CNT_W = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] factor,
    input  wire logic        divide_mode_select,
    output logic             tick
);
    import cgd_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } cgd_div_state_s;

    cgd_div_state_s state;
    cgd_div_state_s next_state;
    logic [CNT_W-1:0] period;

    // ---------------------------------------------------------------
    // period decode
    // ---------------------------------------------------------------
    // exponent clamps to one below the counter width; huge powers cannot be held
    always_comb begin
        logic [16:0] expo;
        expo = {1'b0, factor} + 17'd1;
        if (divide_mode_select) begin
            if (expo > 17'(CNT_W - 1)) begin
                expo = 17'(CNT_W - 1);
            end
            period = CNT_W'(1) << expo;
        end else if (factor <= 16'h0001) begin
            period = CNT_W'(1);
        end else begin
            period = CNT_W'(factor);
        end
    end

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (state.cnt >= period - CNT_W'(1)) begin
            next_state.cnt  = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.cnt  = state.cnt + CNT_W'(1);
            next_state.tick = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;
endmodule
`default_nettype wire

/* verif/cgd_props.sv */
// checker for the generator division-factor register block
// bound to cgd_top by the testbench, sees its ports only
`timescale 1ns/10ps
`default_nettype none
module cgd_props #(
    parameter int CNT_W = 32
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire cgd_pkg::cgd_apb_req_s apb_req,
    input wire cgd_pkg::cgd_apb_rsp_s apb_rsp,
    input wire logic                  user_reset_req,
    input wire logic [5:0]            write_lock,
    input wire logic [5:0]            feeds_rtc,
    input wire logic [5:0]            divide_mode_select,
    input wire logic [5:0]            gen_tick
);
    import cgd_pkg::*;
    logic rd;
    assign rd = apb_rsp.pready && !apb_req.pwrite;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------
    // bus answers
    // --------
    a_ready_setup: assert property (
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (
        apb_rsp.pready |=> !apb_rsp.pready) else $error("long answer");
    a_err_decode: assert property (
        apb_rsp.pready |-> apb_rsp.pslverr == (apb_req.paddr != REG_OFFSET))
        else $error("error flag wrong");
    a_idle_quiet: assert property (
        !rd |-> apb_rsp.prdata == 32'h0) else $error("stray read data");
    a_rsvd_zero: assert property (
        rd |-> apb_rsp.prdata[31:24] == 8'h0 && apb_rsp.prdata[7:4] == 4'h0)
        else $error("reserved bits set");
    a_upper_gen1: assert property (
        rd && apb_rsp.prdata[3:0] != 4'h1 |-> apb_rsp.prdata[23:16] == 8'h0)
        else $error("upper factor bits set");
    a_gen2_width: assert property (
        rd && apb_rsp.prdata[3:0] == 4'h2 |-> apb_rsp.prdata[23:13] == 11'h0)
        else $error("gen2 factor too wide");
    a_user_gen0: assert property (
        user_reset_req [*6] ##0 rd |-> apb_rsp.prdata == 32'h0)
        else $error("user reset left data");
    c_write: cover property (apb_rsp.pready && apb_req.pwrite);
    c_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
    c_user_rd: cover property (user_reset_req && rd);
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the division-factor register block
// drives cgd_top ports directly as an APB master with strobes
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cgd_pkg::*;
    logic         pclk;
    logic         presetn;
    cgd_apb_req_s req;
    cgd_apb_rsp_s rsp;
    logic         ureq;
    logic [5:0]   lock;
    logic [5:0]   rtc;
    logic [5:0]   mode;
    logic [5:0]   tick;
    logic [31:0]  r;
    logic         e;
    int           bad_count;
    int           n_checks;
    int           cnt [6];
    localparam logic [15:0] MK [6] = '{16'h00ff, 16'hffff, 16'h001f,
                                       16'h00ff, 16'h00ff, 16'h00ff};
    // ticks in 48 cycles: gen4 divides by 3, gen5 in mode 1 by 2^(2+1)
    localparam int TK [6] = '{48, 48, 48, 48, 16, 6};
    cgd_top #(.CNT_W(8)) dut (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .user_reset_req(ureq),
        .write_lock(lock), .feeds_rtc(rtc), .divide_mode_select(mode),
        .gen_tick(tick));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // entered just after an edge; holds all until pready is seen
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] q);
        int i;
        @(posedge pclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
                 pwdata: d, pstrb: s};
        @(posedge pclk);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (rsp.pready === 1'b1) break;
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (i == 20) begin
            bad_count++;
            $display("MISMATCH %0t no ready", $time);
            tally_and_finish();
        end
    endtask
    task automatic rd_gen(input int g, input logic [31:0] exp);
        xfer(REG_OFFSET, 1'b1, {28'h0, g[3:0]}, STRB_BYTE0, r);
        xfer(REG_OFFSET, 1'b0, 32'h0, 4'h0, r);
        chk(r, exp);
        chk({31'h0, e}, 32'h0);
    endtask
    // reserved bits kept zero, as software must
    task automatic wr_gen(input int g, input logic [15:0] f);
        xfer(REG_OFFSET, 1'b1, {8'h00, f, 4'h0, g[3:0]}, STRB_FULL,
             r);
    endtask
    function automatic logic [31:0] img(input int g);
        return {8'h0, (16'hffff - g[15:0]) & MK[g], 4'h0, g[3:0]};
    endfunction
    initial begin
        presetn = 1'b0;
        req = '0;
        ureq = 1'b0;
        lock = 6'b00_0011;
        rtc = 6'b00_1000;
        mode = 6'b10_0000;
        bad_count = 0;
        n_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int g = 0; g < 6; g++) rd_gen(g, {28'h0, g[3:0]});
        wr_gen(1, 16'h0001);
        wr_gen(4, 16'h0003);
        wr_gen(5, 16'h0002);
        repeat (20) @(posedge pclk);
        cnt = '{default: 0};
        repeat (48) begin
            @(posedge pclk);
            for (int g = 0; g < 6; g++) cnt[g] += int'(tick[g] === 1'b1);
        end
        for (int g = 0; g < 6; g++) chk(cnt[g], TK[g]);
        for (int g = 0; g < 6; g++) wr_gen(g, 16'hffff - g[15:0]);
        wr_gen(6, 16'h1234);
        xfer(32'h0000_000c, 1'b1, 32'h0000_1200, STRB_FULL, r);
        chk({31'h0, e}, 32'h1);
        xfer(32'h0000_000c, 1'b0, 32'h0, 4'h0, r);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int g = 0; g < 6; g++) rd_gen(g, img(g));
        rd_gen(6, 32'h0000_0006);
        ureq <= 1'b1;
        repeat (8) @(posedge pclk);
        // reset beats the index write, so gen0 answers
        rd_gen(3, 32'h0);
        ureq <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int g = 0; g < 6; g++)
            rd_gen(g, g > 0 && (lock[g] | rtc[g]) ? img(g) : g);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int g = 0; g < 6; g++) rd_gen(g, {28'h0, g[3:0]});
        tally_and_finish();
    end
endmodule
bind cgd_top cgd_props #(.CNT_W(CNT_W)) u_props (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .user_reset_req(user_reset_req), .write_lock(write_lock),
    .feeds_rtc(feeds_rtc), .divide_mode_select(divide_mode_select),
    .gen_tick(gen_tick));
`default_nettype wire
